// ---- dv/dmx_move_exec_chk.sv ----
`timescale 1ns/10ps
// ****************************************
// Port checker for the data-move block
// ****************************************
module dmx_move_exec_chk
    import dmx_pkg::*;
(
    // Clock, reset and register bus
    input wire logic clock, rst_b, read, write, waitrequest,
    input wire logic [9:0] address,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata, readdata,
    // Memory port and core state
    input wire logic mem_rd, mem_wr, zero,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] mem_wdata, mem_rdata, acc,
    input wire logic [5:0] bank_select_reg,
    input wire logic [6:0] pc_upper_latch
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    // Bus answer timing
    property p_rd_wait; read && waitrequest |=> !waitrequest; endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("register read answer late");
    property p_one_ack; (read || write) && !waitrequest |=> waitrequest || (!read && !write); endproperty
    a_one_ack: assert property (p_one_ack) else $error("answer longer than one cycle");
    property p_rd_hold; $changed(readdata) |-> read && !waitrequest; endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved outside an answer");
    // Memory loads, write-backs and stores, accumulator and zero flag
    property p_load; mem_rd ##2 !mem_wr |-> acc == $past(mem_rdata); endproperty
    a_load: assert property (p_load) else $error("loaded value not in accumulator");
    property p_zero; mem_rd ##2 !mem_wr |-> zero == (acc == 8'h00); endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong after load");
    property p_back; mem_rd ##2 mem_wr |-> mem_wdata == $past(mem_rdata) &&
        mem_addr == $past(mem_addr, 2) && $stable(acc); endproperty
    a_back: assert property (p_back) else $error("write back to pointer location wrong");
    property p_store; mem_wr && !$past(mem_rd, 2) |-> mem_wdata == acc; endproperty
    a_store: assert property (p_store) else $error("stored value differs from accumulator");
    property p_pulse; mem_rd |=> !mem_rd && !mem_wr; endproperty
    a_pulse: assert property (p_pulse) else $error("memory read strobe too long");
    property p_lit_flags; $changed(bank_select_reg) || $changed(pc_upper_latch) |-> $stable(zero); endproperty
    a_lit_flags: assert property (p_lit_flags) else $error("literal load touched zero flag");
    // Main scenarios reached
    c_load: cover property (mem_rd ##2 !mem_wr);
    c_back: cover property (mem_rd ##2 mem_wr);
    c_store: cover property (mem_wr && !$past(mem_rd, 2));
endmodule
bind dmx_move_exec dmx_move_exec_chk dmx_move_exec_chk_i (.clock(clock), .rst_b(rst_b), .read(read), .write(write),
    .waitrequest(waitrequest), .address(address), .byteenable(byteenable), .writedata(writedata),
    .readdata(readdata), .mem_rd(mem_rd), .mem_wr(mem_wr), .zero(zero), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .acc(acc), .bank_select_reg(bank_select_reg),
    .pc_upper_latch(pc_upper_latch));

// ---- dv/dmx_move_exec_tb.sv ----
`timescale 1ns/10ps
// ****************************************
// Bench for the data-move block
// ****************************************
module dmx_move_exec_tb;
    import dmx_pkg::*;
    logic clock, rst_b, read, write, waitrequest, mem_rd, mem_wr, zero;
    logic [9:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata, readdata, q;
    logic [15:0] mem_addr, p, np, ea;
    logic [7:0] mem_wdata, mem_rdata, acc;
    logic [5:0] bank_select_reg;
    logic [6:0] pc_upper_latch;
    logic [7:0] dmem [0:65535];
    int err_count, comparisons;
    dmx_move_exec dmx_move_exec_i (.clock(clock), .rst_b(rst_b), .address(address), .read(read), .write(write),
        .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .acc(acc), .zero(zero), .bank_select_reg(bank_select_reg), .pc_upper_latch(pc_upper_latch));
    // Core clock
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // Data memory, one cycle read latency, read lines toggle when idle
    always @(posedge clock) begin
        if (mem_wr) dmem[mem_addr] <= mem_wdata;
        mem_rdata <= !rst_b ? 8'h00 : mem_rd ? dmem[mem_addr] : ~mem_rdata;
    end
    // Compare and count
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic test_done;
        $display("Comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // One bus transfer held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 40);
        if (waitrequest !== 1'b0) begin
            err_count++;
            test_done();
        end
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [31:0] e, input string nm);
        bus(1'b0, a, 32'h0000_0000);
        check(nm, q, e);
    endtask
    task automatic ex(input logic [13:0] w);
        bus(1'b1, DMX_OFF_INSTR, 32'(w));
    endtask
    // Main sequence
    initial begin
        rst_b = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 10'h000;
        writedata = 32'h0000_0000;
        byteenable = 4'hF;
        err_count = 0;
        comparisons = 0;
        for (int i = 0; i < 65536; i++) dmem[i] = 8'(i[7:0] + i[15:8]);
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        rd(DMX_OFF_ACC, 32'h0000_0000, "acc reset");
        rd(DMX_OFF_PTR1, 32'h0000_0000, "ptr1 reset");
        rd(10'h01C, 32'h0000_0000, "unmapped");
        $display("test reset done");
        ex(14'h0805);
        check("zero set", zero, 1);
        ex(14'h37A5);
        check("acc literal", acc, 8'hA5);
        for (int k = 0; k < 64; k += 63) begin
            ex(14'h0140 | 14'(k));
            check("bank", bank_select_reg, k);
        end
        ex(14'h31FF);
        check("latch", pc_upper_latch, 7'h7F);
        check("zero kept", zero, 1);
        $display("test literal done");
        ex(14'h00FF);
        rd(10'h3FC, 32'h0000_00A5, "store");
        ex(14'h3400);
        ex(14'h08FF);
        check("zero test", zero, 0);
        check("acc kept", acc, 8'h00);
        ex(14'h087F);
        check("move acc", acc, 8'hA5);
        $display("test file move done");
        for (int i = 0; i < 8; i++) begin
            p = i[0] ? 16'h0000 : 16'hFFFF;
            np = i[0] ? p - 16'h0001 : p + 16'h0001;
            ea = i[1] ? p : np;
            bus(1'b1, i[2] ? DMX_OFF_PTR1 : DMX_OFF_PTR0, {16'h0000, p});
            ex(14'h0010 | 14'(i));
            check("iload acc", acc, dmem[ea]);
            check("iload zero", zero, dmem[ea] == 8'h00);
            rd(i[2] ? DMX_OFF_PTR1 : DMX_OFF_PTR0, {16'h0000, np}, "ptr update");
        end
        bus(1'b1, DMX_OFF_PTR1, 32'h0000_0010);
        ex(14'h3F60);
        check("rel neg", acc, dmem[16'hFFF0]);
        ex(14'h3F5F);
        check("rel pos", acc, dmem[16'h002F]);
        rd(DMX_OFF_PTR1, 32'h0000_0010, "rel ptr");
        $display("test indirect done");
        bus(1'b1, DMX_OFF_PTR0, 32'h0000_1234);
        ex(14'h3400);
        ex(14'h0080);
        check("port store", dmem[16'h1234], 8'h00);
        ex(14'h3477);
        ex(14'h0800);
        check("port acc", acc, 8'h00);
        check("port zero", zero, 1);
        rd(DMX_OFF_PTR0, 32'h0000_1234, "port ptr");
        byteenable <= 4'h1;
        bus(1'b1, DMX_OFF_PTR0, 32'h0000_ABCD);
        byteenable <= 4'hF;
        rd(DMX_OFF_PTR0, 32'h0000_12CD, "lane ptr");
        ex(14'h0881);
        check("port back", dmem[16'h0010], 8'h10);
        check("zero back", zero, 0);
        $display("test port done");
        test_done();
    end
endmodule

// ---- rtl/dmx_move_exec.sv ----
// Operation
// (RL1) A file move reads the 7-bit addressed file register and writes it to the accumulator when d is 0, else back.
// (RL2) A file move updates the zero flag from the moved value for either destination.
// (RL3) An instruction that updates zero sets it for a zero 8-bit result and clears it otherwise.
// (RL4) The indirect load picks a pointer by a one-bit index, loads memory into the accumulator, updates zero.
// (RL5) The indirect data port has no storage and any access goes to the address its pointer holds; bus window accesses to indexes 0 and 1 use file_regs.
// (RL6) The 2-bit mode selects preincrement, predecrement, postincrement or postdecrement for codes 0 to 3.
// (RL7) Pre modes address with the updated pointer, post modes with the old one, and the pointer keeps the update.
// (RL8) The relative form addresses pointer plus a signed offset from -32 to 31 and leaves the pointer alone.
// (RL9) Pointers are 16 bits and wrap modulo the range on increment and decrement.
// (RL10) The bank literal load puts a 6-bit literal into the bank select register without touching flags.
// (RL11) The latch literal load puts a 7-bit literal into the upper program-counter latch without touching flags.
// (RL12) The accumulator literal load puts an 8-bit literal into the accumulator in one cycle without touching flags.
// (RL13) The unused opcode bits of the accumulator literal load are ignored by the decoder.
// (RL14) The accumulator store copies the accumulator into the addressed file register without touching flags.
`timescale 1ns/10ps
module dmx_move_exec (
    // Clock and reset
    input  wire logic                          clock,
    input  wire logic                          rst_b,
    // Avalon-MM slave
    input  wire logic [dmx_pkg::DMX_ADDR_W-1:0] address,
    input  wire logic                          read,
    input  wire logic                          write,
    input  wire logic [3:0]                    byteenable,
    input  wire logic [31:0]                   writedata,
    output logic      [31:0]                   readdata,
    output logic                               waitrequest,
    // Data memory port
    output logic      [15:0]                   mem_addr,
    output logic                               mem_rd,
    output logic                               mem_wr,
    output logic      [7:0]                    mem_wdata,
    input  wire logic [7:0]                    mem_rdata,
    // Core state view
    output logic      [7:0]                    acc,
    output logic                               zero,
    output logic      [5:0]                    bank_select_reg,
    output logic      [6:0]                    pc_upper_latch
);
    import dmx_pkg::*;

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic op_is(input logic [13:0] word, input logic [13:0] msk, input logic [13:0] pat);
        op_is = ((word & msk) == pat);
    endfunction

    function automatic logic is_zero(input logic [7:0] value);
        is_zero = (value == 8'h00);                    // (RL3)
    endfunction

    function automatic logic [15:0] lane16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
        lane16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    function automatic logic is_port(input logic [6:0] faddr);
        is_port = (faddr == DMX_PORT0) || (faddr == DMX_PORT1);
    endfunction

    // ************************************************************
    // State
    // ************************************************************
    dmx_state_type state;
    dmx_state_type next_state;
    logic [13:0]   instr;
    logic [13:0]   next_instr;
    logic [7:0]    next_acc;
    logic          next_zero;
    logic [5:0]    next_bank;
    logic [6:0]    next_pcl;
    logic [15:0]   ptr0;
    logic [15:0]   ptr1;
    logic [15:0]   next_ptr0;
    logic [15:0]   next_ptr1;
    logic [31:0]   next_readdata;
    logic [15:0]   next_mem_addr;
    logic          next_mem_rd;
    logic          next_mem_wr;
    logic [7:0]    next_mem_wdata;
    logic [7:0]    file_regs [0:127];
    logic          file_we;
    logic [6:0]    file_waddr;
    logic [7:0]    file_wdata;

    // ************************************************************
    // Decode
    // ************************************************************
    logic          op_fmove;
    logic          op_store;
    logic          op_alit;
    logic          op_blit;
    logic          op_plit;
    logic          op_iload;
    logic          op_irel;
    logic [6:0]    fsel;
    logic          fdir;
    logic          psel;
    logic [15:0]   psel_value;
    logic [15:0]   port_ptr;
    logic [15:0]   unit_addr;
    logic [15:0]   unit_next;
    logic [6:0]    bus_index;

    // Opcode classes; alit ignores its two unused bits
    assign op_fmove = op_is(instr, DMX_MSK_FMOVE, DMX_PAT_FMOVE);
    assign op_store = op_is(instr, DMX_MSK_STORE, DMX_PAT_STORE);
    assign op_alit  = op_is(instr, DMX_MSK_ALIT, DMX_PAT_ALIT);  // (RL13)
    assign op_blit  = op_is(instr, DMX_MSK_BLIT, DMX_PAT_BLIT);
    assign op_plit  = op_is(instr, DMX_MSK_PLIT, DMX_PAT_PLIT);
    assign op_iload = op_is(instr, DMX_MSK_ILOAD, DMX_PAT_ILOAD);
    assign op_irel  = op_is(instr, DMX_MSK_IREL, DMX_PAT_IREL);

    // Operand fields and pointer selection
    assign fsel       = instr[6:0];
    assign fdir       = instr[DMX_DIR_BIT];
    assign psel       = op_irel ? instr[DMX_RSEL_BIT] : instr[DMX_MSEL_BIT]; // (RL4)
    assign psel_value = psel ? ptr1 : ptr0;
    assign port_ptr   = (fsel == DMX_PORT1) ? ptr1 : ptr0;            // (RL5)
    assign bus_index  = address[8:2];

    // Effective address and pointer update
    dmx_ptr_unit dmx_ptr_unit_i (
        .pointer             (psel_value),
        .pointer_update_mode (instr[1:0]),
        .relative            (op_irel),
        .offset              (instr[5:0]),
        .eff_addr            (unit_addr),
        .next_pointer        (unit_next)
    );

    // Hold the master until the answer is ready
    assign waitrequest = (read || write) && (state != DMX_ST_ACK);

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        next_state     = state;
        next_instr     = instr;
        next_acc       = acc;
        next_zero      = zero;
        next_bank      = bank_select_reg;
        next_pcl       = pc_upper_latch;
        next_ptr0      = ptr0;
        next_ptr1      = ptr1;
        next_readdata  = readdata;
        next_mem_addr  = mem_addr;
        next_mem_rd    = 1'b0;
        next_mem_wr    = 1'b0;
        next_mem_wdata = mem_wdata;
        file_we        = 1'b0;
        file_waddr     = fsel;
        file_wdata     = acc;
        case (state)
            DMX_ST_IDLE: begin
                if (read) begin
                    next_readdata = 32'h0000_0000;
                    if (address >= DMX_OFF_FILE) begin
                        next_readdata[7:0] = file_regs[bus_index];
                    end else begin
                        case (address)
                            DMX_OFF_INSTR: next_readdata[13:0] = instr;
                            DMX_OFF_ACC:   next_readdata[7:0]  = acc;
                            DMX_OFF_STAT:  next_readdata[DMX_STAT_Z] = zero;
                            DMX_OFF_BANK:  next_readdata[5:0]  = bank_select_reg;
                            DMX_OFF_PCL:   next_readdata[6:0]  = pc_upper_latch;
                            DMX_OFF_PTR0:  next_readdata[15:0] = ptr0;
                            DMX_OFF_PTR1:  next_readdata[15:0] = ptr1;
                            default:       next_readdata = 32'h0000_0000;
                        endcase
                    end
                    next_state = DMX_ST_ACK;
                end else if (write) begin
                    next_state = DMX_ST_ACK;
                    if (address >= DMX_OFF_FILE) begin
                        file_we    = byteenable[0];
                        file_waddr = bus_index;
                        file_wdata = writedata[7:0];
                    end else begin
                        case (address)
                            DMX_OFF_INSTR: begin
                                next_instr = writedata[13:0];
                                next_state = DMX_ST_EXEC;
                            end
                            DMX_OFF_ACC:  if (byteenable[0]) next_acc = writedata[7:0];
                            DMX_OFF_BANK: if (byteenable[0]) next_bank = writedata[5:0];
                            DMX_OFF_PCL:  if (byteenable[0]) next_pcl = writedata[6:0];
                            DMX_OFF_PTR0: next_ptr0 = lane16(ptr0, writedata, byteenable);
                            DMX_OFF_PTR1: next_ptr1 = lane16(ptr1, writedata, byteenable);
                            default:      next_state = DMX_ST_ACK;
                        endcase
                    end
                end
            end
            DMX_ST_EXEC: begin
                next_state = DMX_ST_ACK;
                if (op_fmove) begin
                    if (is_port(fsel)) begin
                        next_mem_addr = port_ptr;                         // (RL5)
                        next_mem_rd   = 1'b1;
                        next_state    = DMX_ST_MEM;
                    end else begin
                        next_zero = is_zero(file_regs[fsel]);             // (RL2)
                        if (fdir) begin
                            file_we    = 1'b1;                            // (RL1)
                            file_wdata = file_regs[fsel];
                        end else begin
                            next_acc = file_regs[fsel];                   // (RL1)
                        end
                    end
                end else if (op_store) begin
                    if (is_port(fsel)) begin
                        next_mem_addr  = port_ptr;                        // (RL5)
                        next_mem_wdata = acc;
                        next_mem_wr    = 1'b1;
                        next_state     = DMX_ST_WB;
                    end else begin
                        file_we    = 1'b1;                                // (RL14)
                        file_wdata = acc;
                    end
                end else if (op_iload || op_irel) begin
                    next_mem_addr = unit_addr;                            // (RL7)
                    next_mem_rd   = 1'b1;
                    next_state    = DMX_ST_MEM;
                    if (psel) begin
                        next_ptr1 = unit_next;                            // (RL7)
                    end else begin
                        next_ptr0 = unit_next;                            // (RL7)
                    end
                end else if (op_alit) begin
                    next_acc = instr[7:0];                                // (RL12)
                end else if (op_blit) begin
                    next_bank = instr[5:0];                               // (RL10)
                end else if (op_plit) begin
                    next_pcl = instr[6:0];                                // (RL11)
                end
            end
            DMX_ST_MEM: begin
                next_state = DMX_ST_CAP;
            end
            DMX_ST_CAP: begin
                next_zero  = is_zero(mem_rdata);                          // (RL2)
                next_state = DMX_ST_ACK;
                if (op_fmove && fdir) begin
                    next_mem_wdata = mem_rdata;                           // (RL1)
                    next_mem_wr    = 1'b1;
                    next_state     = DMX_ST_WB;
                end else begin
                    next_acc = mem_rdata;                                 // (RL4)
                end
            end
            DMX_ST_WB: begin
                next_state = DMX_ST_ACK;
            end
            DMX_ST_ACK: begin
                next_state = DMX_ST_IDLE;
            end
            default: begin
                next_state = DMX_ST_IDLE;
            end
        endcase
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state           <= DMX_ST_IDLE;
            instr           <= DMX_RST_INSTR;
            acc             <= DMX_RST_ACC;
            zero            <= 1'b0;
            bank_select_reg <= DMX_RST_BANK;
            pc_upper_latch  <= DMX_RST_PCL;
            ptr0            <= DMX_RST_PTR;
            ptr1            <= DMX_RST_PTR;
            readdata        <= 32'h0000_0000;
            mem_addr        <= DMX_RST_PTR;
            mem_rd          <= 1'b0;
            mem_wr          <= 1'b0;
            mem_wdata       <= DMX_RST_ACC;
        end else begin
            state           <= next_state;
            instr           <= next_instr;
            acc             <= next_acc;
            zero            <= next_zero;
            bank_select_reg <= next_bank;
            pc_upper_latch  <= next_pcl;
            ptr0            <= next_ptr0;
            ptr1            <= next_ptr1;
            readdata        <= next_readdata;
            mem_addr        <= next_mem_addr;
            mem_rd          <= next_mem_rd;
            mem_wr          <= next_mem_wr;
            mem_wdata       <= next_mem_wdata;
        end
    end

    // File register array
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < 128; i++) begin
                file_regs[i] <= DMX_RST_FILE;
            end
        end else if (file_we) begin
            file_regs[file_waddr] <= file_wdata;
        end
    end
endmodule

// ---- rtl/dmx_pkg.sv ----
// ************************************************************
// Data-move execution constants
// ************************************************************
package dmx_pkg;

    // ************************************************************
    // Register bus
    // ************************************************************
    localparam int           DMX_ADDR_W    = 10;
    localparam logic [9:0]   DMX_OFF_INSTR = 10'h000;
    localparam logic [9:0]   DMX_OFF_ACC   = 10'h004;
    localparam logic [9:0]   DMX_OFF_STAT  = 10'h008;
    localparam logic [9:0]   DMX_OFF_BANK  = 10'h00C;
    localparam logic [9:0]   DMX_OFF_PCL   = 10'h010;
    localparam logic [9:0]   DMX_OFF_PTR0  = 10'h014;
    localparam logic [9:0]   DMX_OFF_PTR1  = 10'h018;
    localparam logic [9:0]   DMX_OFF_FILE  = 10'h200;
    localparam int           DMX_STAT_Z    = 0;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [13:0]  DMX_RST_INSTR = 14'h0000;
    localparam logic [7:0]   DMX_RST_ACC   = 8'h00;
    localparam logic [5:0]   DMX_RST_BANK  = 6'h00;
    localparam logic [6:0]   DMX_RST_PCL   = 7'h00;
    localparam logic [15:0]  DMX_RST_PTR   = 16'h0000;
    localparam logic [7:0]   DMX_RST_FILE  = 8'h00;

    // ************************************************************
    // Opcode masks and patterns
    // ************************************************************
    localparam logic [13:0]  DMX_MSK_FMOVE = 14'h3F00;
    localparam logic [13:0]  DMX_PAT_FMOVE = 14'h0800;
    localparam logic [13:0]  DMX_MSK_STORE = 14'h3F80;
    localparam logic [13:0]  DMX_PAT_STORE = 14'h0080;
    localparam logic [13:0]  DMX_MSK_ALIT  = 14'h3C00;
    localparam logic [13:0]  DMX_PAT_ALIT  = 14'h3400;
    localparam logic [13:0]  DMX_MSK_BLIT  = 14'h3FC0;
    localparam logic [13:0]  DMX_PAT_BLIT  = 14'h0140;
    localparam logic [13:0]  DMX_MSK_PLIT  = 14'h3F80;
    localparam logic [13:0]  DMX_PAT_PLIT  = 14'h3180;
    localparam logic [13:0]  DMX_MSK_ILOAD = 14'h3FF8;
    localparam logic [13:0]  DMX_PAT_ILOAD = 14'h0010;
    localparam logic [13:0]  DMX_MSK_IREL  = 14'h3F80;
    localparam logic [13:0]  DMX_PAT_IREL  = 14'h3F00;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int           DMX_DIR_BIT   = 7;
    localparam int           DMX_MSEL_BIT  = 2;
    localparam int           DMX_RSEL_BIT  = 6;
    localparam logic [6:0]   DMX_PORT0     = 7'h00;
    localparam logic [6:0]   DMX_PORT1     = 7'h01;

    // ************************************************************
    // Pointer update modes
    // ************************************************************
    localparam logic [1:0]   DMX_MODE_PREINC  = 2'h0;
    localparam logic [1:0]   DMX_MODE_PREDEC  = 2'h1;
    localparam logic [1:0]   DMX_MODE_POSTINC = 2'h2;
    localparam logic [1:0]   DMX_MODE_POSTDEC = 2'h3;

    typedef enum logic [2:0] {
        DMX_ST_IDLE,
        DMX_ST_EXEC,
        DMX_ST_MEM,
        DMX_ST_CAP,
        DMX_ST_WB,
        DMX_ST_ACK
    } dmx_state_type;

endpackage

// ---- rtl/dmx_ptr_unit.sv ----
`timescale 1ns/10ps
module dmx_ptr_unit (
    // Pointer and instruction fields
    input  wire logic [15:0] pointer,
    input  wire logic [1:0]  pointer_update_mode,
    input  wire logic        relative,
    input  wire logic [5:0]  offset,
    // Results
    output logic      [15:0] eff_addr,
    output logic      [15:0] next_pointer
);
    import dmx_pkg::*;

    logic [15:0] plus_one;
    logic [15:0] minus_one;
    logic [15:0] rel_addr;

    // Sixteen-bit sums wrap modulo the range by width
    assign plus_one  = pointer + 16'h0001;             // (RL9)
    assign minus_one = pointer - 16'h0001;             // (RL9)
    assign rel_addr  = pointer + {{10{offset[5]}}, offset}; // (RL8)

    // Address and pointer choice per mode
    always_comb begin
        eff_addr     = pointer;
        next_pointer = pointer;
        if (relative) begin
            eff_addr     = rel_addr;                   // (RL8)
            next_pointer = pointer;
        end else begin
            case (pointer_update_mode)                 // (RL6)
                DMX_MODE_PREINC: begin
                    eff_addr     = plus_one;           // (RL7)
                    next_pointer = plus_one;
                end
                DMX_MODE_PREDEC: begin
                    eff_addr     = minus_one;          // (RL7)
                    next_pointer = minus_one;
                end
                DMX_MODE_POSTINC: begin
                    eff_addr     = pointer;            // (RL7)
                    next_pointer = plus_one;
                end
                DMX_MODE_POSTDEC: begin
                    eff_addr     = pointer;            // (RL7)
                    next_pointer = minus_one;
                end
                default: begin
                    eff_addr     = pointer;
                    next_pointer = pointer;
                end
            endcase
        end
    end
endmodule
